// >>> common/ixw_consts.svh
// Constants for the interrupt and wake-up controller
`ifndef IXW_CONSTS_SVH
`define IXW_CONSTS_SVH
`define IXW_IOR_ADDR    8'hC8
`define IXW_ENA_ADDR    8'hCC
`define IXW_STAT_ADDR   8'hD0
`define IXW_IOR_RST     8'h00
`define IXW_IOR_MASK    8'h70
`define IXW_ENA_RST     8'h00
`define IXW_LES_BIT     6
`define IXW_ESB_BIT     5
`define IXW_GEN_BIT     4
`define IXW_EN_TMR1     0
`define IXW_EN_WRAP     1
`define IXW_EN_MATCH    2
`define IXW_EN_CONV     3
`define IXW_EN_RX       4
`define IXW_EN_TX       5
`define IXW_VEC_NMI     12'hFFC
`define IXW_VEC_SRC1    12'hFF6
`define IXW_VEC_SRC2    12'hFF4
`define IXW_VEC_SRC3    12'hFF2
`define IXW_VEC_SRC4    12'hFF0
`define IXW_PIN_IDLE    3'h7
`define IXW_RESP_OKAY   2'h0
`define IXW_RESP_SLVERR 2'h2
`define IXW_STAB_NS     20000
`define IXW_CLK_NS      10
`define IXW_STAB_CYC    ((`IXW_STAB_NS + `IXW_CLK_NS - 1) / `IXW_CLK_NS)
`endif

// >>> common/ixw_pkg.sv
// Types shared by the interrupt and wake-up controller
package ixw_pkg;
    typedef enum logic [1:0] {FS_NORMAL, FS_IRQ, FS_NMI} ixw_flagset_e;
    typedef enum logic [1:0] {PW_RUN, PW_WAIT, PW_STOP, PW_STAB} ixw_pwr_e;
    typedef struct packed {
        logic spi_done;
        logic timer1_zero_flag;
        logic reload_timer_wrap_flag;
        logic reload_timer_match_flag;
        logic converter_eoc;
        logic serial_byte_received_flag;
        logic serial_byte_sent_flag;
    } ixw_periph_s;
    typedef struct packed {
        logic [11:0]  vector;
        ixw_flagset_e flag_set;
    } ixw_entry_s;
endpackage

// >>> verif/ixw_core_model.sv
// Core model: instruction slots, queued core commands, stack depth
`timescale 1ns/100ps
module ixw_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Bench control: run gates slots, cmd 1 return, 2 wait, 3 stop
    input  wire logic       run,
    input  wire logic [1:0] cmd,
    // Controller outputs
    input  wire logic       halt,
    input  wire logic       push,
    input  wire logic       pop,
    // Core strobes and stack depth
    output logic            instr_end = 1'b0,
    output logic            return_from_irq_instr_exec = 1'b0,
    output logic            wait_exec = 1'b0,
    output logic            stop_exec = 1'b0,
    output int              depth = 0
);
    logic [1:0] slot_ff = 2'h0;
    logic [1:0] pend_ff = 2'h0;
    logic       fire;
    // A command takes the place of an instruction end, so return never coincides with one
    assign fire = run && !halt && slot_ff == 2'h3;
    always @(posedge clk) begin
        slot_ff   <= rst ? 2'h0 : slot_ff + 2'h1;
        pend_ff   <= rst ? 2'h0 : (cmd != 2'h0) ? cmd : fire ? 2'h0 : pend_ff;
        depth     <= rst ? 0 : depth + int'(push) - int'(pop);
        instr_end <= !rst && fire && pend_ff == 2'h0;
        return_from_irq_instr_exec <= !rst && fire && pend_ff == 2'h1;
        wait_exec <= !rst && fire && pend_ff == 2'h2;
        stop_exec <= !rst && fire && pend_ff == 2'h3;
    end
endmodule // ixw_core_model

// >>> verif/ixw_ctrl_test.sv
// Self-checking bench for the interrupt and wake-up controller
`timescale 1ns/100ps
`include "ixw_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("FAIL at %0t got %0h exp %0h", $time, (a), (e)); end end
module ixw_ctrl_test;
    logic                  ref_clk = 1'b0, sys_rst = 1'b1, wdog = 1'b0, run = 1'b1;
    logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                  nmi_n = 1'b1, src1_n = 1'b1, src2 = 1'b1;
    logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]           wdata = 32'h0, rdata;
    logic [1:0]            cmd = 2'h0, bresp, rresp;
    logic                  awready, wready, bvalid, arready, rvalid, entry_pulse, pc_push, pc_pop;
    logic                  instr_end, return_from_irq_instr_exec, wait_exec, stop_exec, core_halt, osc_run;
    ixw_pkg::ixw_periph_s  periph = 7'h00;
    ixw_pkg::ixw_entry_s   entry, exp_e;
    ixw_pkg::ixw_entry_s   exp_q[$];
    ixw_pkg::ixw_flagset_e flag_set;
    int                    depth, failures = 0, n_checks = 0, cyc = 0, seed = 32'hf6bdeab3, i, k, t, ena;

    ixw_ctrl i_dut (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready),
        .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
        .RDATA(rdata), .RRESP(rresp), .INSTR_END(instr_end), .RETURN_FROM_IRQ_INSTR_EXEC(return_from_irq_instr_exec), .WAIT_EXEC(wait_exec),
        .STOP_EXEC(stop_exec), .WDOG_ACTIVE(wdog), .ENTRY_PULSE(entry_pulse), .ENTRY(entry), .PC_PUSH(pc_push),
        .PC_POP(pc_pop), .FLAG_SET(flag_set), .CORE_HALT(core_halt), .OSC_RUN(osc_run), .NMI_N(nmi_n),
        .SRC1_N(src1_n), .SRC2_PIN(src2), .PERIPH(periph)
    );
    ixw_core_model i_core (
        .clk(ref_clk), .rst(sys_rst), .run(run), .cmd(cmd), .halt(core_halt), .push(pc_push), .pop(pc_pop),
        .instr_end(instr_end), .return_from_irq_instr_exec(return_from_irq_instr_exec), .wait_exec(wait_exec), .stop_exec(stop_exec), .depth(depth)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Longest run is under 3000 cycles, the STOP settling included
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // every entry is matched in order against the model queue
    always @(posedge ref_clk) begin
        if (!sys_rst && entry_pulse === 1'b1) begin
            exp_e = 14'h3FFF;
            if (exp_q.size() != 0) exp_e = exp_q.pop_front();
            `CHK(entry, exp_e)
            `CHK(flag_set, exp_e.flag_set)
            `CHK(pc_push, 1'b1)
        end
    end

    task automatic xp(input logic [11:0] v, input ixw_pkg::ixw_flagset_e f);
        exp_e.vector = v;
        exp_e.flag_set = f;
        exp_q.push_back(exp_e);
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw = 1'b0;
        logic w = 1'b0;
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            aw = aw | (awready === 1'b1);
            w = w | (wready === 1'b1);
            awvalid <= !aw;
            wvalid <= !w;
        end while (!(aw && w));
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        `CHK(rdata, ed)
        `CHK(rresp, er)
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic issue(input logic [1:0] c);
        cmd <= c;
        @(posedge ref_clk);
        cmd <= 2'h0;
    endtask

    // Two extra edges let the stack depth catch up with the entry
    task automatic wait_n(input int n);
        for (t = 0; t < 80 && exp_q.size() > n; t++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        `CHK(exp_q.size() > n, 1'b0)
    endtask

    task automatic return_from_irq_instr(input ixw_pkg::ixw_flagset_e f, input int d);
        issue(2'h1);
        do @(posedge ref_clk); while (pc_pop !== 1'b1);
        `CHK(flag_set, f)
        @(posedge ref_clk);
        `CHK(depth, d)
    endtask

    task automatic wait_halt;
        do @(posedge ref_clk); while (core_halt !== 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        axr(8'hC8, 32'h0, 2'h0);
        axr(8'h40, 32'h0, 2'h2);
        axw(8'h40, 8'hFF, 2'h2);
        // Option clear after reset: maskables blocked, NMI served
        axw(8'hCC, 8'h3F, 2'h0);
        periph.converter_eoc <= 1'b1;
        repeat (20) @(posedge ref_clk);
        periph <= 7'h00;
        xp(`IXW_VEC_NMI, ixw_pkg::FS_NMI);
        nmi_n <= 1'b0;
        wait_n(0);
        nmi_n <= 1'b1;
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        axw(8'hC8, 8'h10, 2'h0);
        axr(8'hC8, 32'h0, 2'h0);
        // Each timer, converter and serial event with random enables
        for (k = 0; k < 12; k++) begin
            i = k % 6;
            ena = $random(seed);
            if (k < 6) ena[i] = 1'b1;
            axw(8'hCC, {2'h0, ena[5:0]}, 2'h0);
            periph <= 7'h01 << (5 - i);
            if (ena[i]) xp(i < 3 ? `IXW_VEC_SRC3 : `IXW_VEC_SRC4, ixw_pkg::FS_IRQ);
            wait_n(0);
            repeat (8) @(posedge ref_clk);
            periph <= 7'h00;
            if (ena[i]) return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        end
        // Pending requests gathered while the core is held, two rising edges on source two
        axw(8'hC8, 8'h30, 2'h0);
        axw(8'hCC, 8'h08, 2'h0);
        run <= 1'b0;
        src1_n <= 1'b0;
        for (k = 0; k < 4; k++) begin
            repeat (6) @(posedge ref_clk);
            src2 <= !src2;
        end
        periph.converter_eoc <= 1'b1;
        repeat (8) @(posedge ref_clk);
        xp(`IXW_VEC_SRC1, ixw_pkg::FS_IRQ);
        xp(`IXW_VEC_SRC2, ixw_pkg::FS_IRQ);
        xp(`IXW_VEC_SRC4, ixw_pkg::FS_IRQ);
        run <= 1'b1;
        wait_n(2);
        src1_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        `CHK(depth, 1)
        exp_e.vector = `IXW_VEC_NMI;
        exp_e.flag_set = ixw_pkg::FS_NMI;
        exp_q.push_front(exp_e);
        nmi_n <= 1'b0;
        wait_n(2);
        nmi_n <= 1'b1;
        `CHK(depth, 2)
        return_from_irq_instr(ixw_pkg::FS_IRQ, 1);
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        wait_n(1);
        repeat (12) @(posedge ref_clk);
        `CHK(depth, 1)
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        wait_n(0);
        periph <= 7'h00;
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        repeat (30) @(posedge ref_clk);
        // Polarity clear: falling edge on source two
        axw(8'hC8, 8'h10, 2'h0);
        xp(`IXW_VEC_SRC2, ixw_pkg::FS_IRQ);
        src2 <= 1'b0;
        wait_n(0);
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        // Level mode re-enters while the pin stays low
        axw(8'hC8, 8'h50, 2'h0);
        xp(`IXW_VEC_SRC1, ixw_pkg::FS_IRQ);
        xp(`IXW_VEC_SRC1, ixw_pkg::FS_IRQ);
        src1_n <= 1'b0;
        wait_n(1);
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        wait_n(0);
        src1_n <= 1'b1;
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        // WAIT, then STOP under watchdog which must act as WAIT
        axw(8'hC8, 8'h10, 2'h0);
        for (k = 0; k < 2; k++) begin
            wdog <= k[0];
            issue(k ? 2'h3 : 2'h2);
            wait_halt();
            `CHK(osc_run, 1'b1)
            xp(`IXW_VEC_SRC4, ixw_pkg::FS_IRQ);
            periph.converter_eoc <= 1'b1;
            for (t = 0; t < 20 && core_halt === 1'b1; t++) @(posedge ref_clk);
            `CHK(t <= 3, 1'b1)
            wait_n(0);
            periph <= 7'h00;
            return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        end
        wdog <= 1'b0;
        // Real STOP: oscillator off, wake by pin edge after settling
        src2 <= 1'b1;
        issue(2'h3);
        wait_halt();
        `CHK(osc_run, 1'b0)
        xp(`IXW_VEC_SRC2, ixw_pkg::FS_IRQ);
        src2 <= 1'b0;
        for (t = 0; t < 2100 && core_halt === 1'b1; t++) @(posedge ref_clk);
        `CHK(t >= `IXW_STAB_CYC && t <= `IXW_STAB_CYC + 12, 1'b1)
        `CHK(osc_run, 1'b1)
        wait_n(0);
        return_from_irq_instr(ixw_pkg::FS_NORMAL, 0);
        // Global enable clear: NMI cannot wake STOP, reset does
        axw(8'hC8, 8'h00, 2'h0);
        issue(2'h3);
        wait_halt();
        nmi_n <= 1'b0;
        repeat (40) @(posedge ref_clk);
        `CHK(core_halt, 1'b1)
        nmi_n <= 1'b1;
        src2 <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        `CHK(core_halt, 1'b0)
        `CHK(flag_set, ixw_pkg::FS_NORMAL)
        repeat (30) @(posedge ref_clk);
        report_and_stop();
    end
endmodule // ixw_ctrl_test

// >>> verilog/ixw_ctrl.sv
// Interrupt sequencing and WAIT/STOP wake-up control with AXI4-Lite registers
// Notes on behaviour
// RULE1 - Entry swaps flags to interrupt or NMI set
// RULE2 - Entry pushes program counter onto stack
// RULE3 - Entry inhibits maskable lines, NMI stays live
// RULE4 - Entry clears source latch, then loads vector
// RULE5 - Return restores previous flags, pops counter
// RULE6 - Option register write-only at C8, resets zero
// RULE7 - Bit six selects level mode, source one
// RULE8 - Bit five selects source two edge polarity
// RULE9 - Bit four enables all but NMI
// RULE10 - Global enable low: NMI serviced, no wake
// RULE11 - Timer events gated onto source three
// RULE12 - Converter end gated onto source four
// RULE13 - Serial events gated onto source four
// RULE14 - WAIT halts core, oscillator keeps running
// RULE15 - WAIT wake-up adds no stabilisation delay
// RULE16 - STOP needs watchdog off, halts oscillator
// RULE17 - STOP wake-up waits for oscillator settling
// RULE18 - Reset during WAIT/STOP takes reset path
// RULE19 - Main-routine wake services interrupt then continues
// RULE20 - NMI-routine wake resumes, stays in NMI
// RULE21 - Oscillator selection never touched by wake
// RULE22 - NMI preempts; maskables fixed priority, no nesting
// RULE23 - Edge latch holds one request until entry
// RULE24 - Requests sampled at every instruction end
// RULE25 - Polarity set rising, cleared falling
`timescale 1ns/100ps
`include "ixw_consts.svh"
module ixw_ctrl (
    // Clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                SYS_RST,
    // AXI4-Lite slave
    input  wire logic                AWVALID,
    output logic                     AWREADY,
    input  wire logic [7:0]          AWADDR,
    input  wire logic                WVALID,
    output logic                     WREADY,
    input  wire logic [31:0]         WDATA,
    input  wire logic [3:0]          WSTRB,
    output logic                     BVALID,
    input  wire logic                BREADY,
    output logic [1:0]               BRESP,
    input  wire logic                ARVALID,
    output logic                     ARREADY,
    input  wire logic [7:0]          ARADDR,
    output logic                     RVALID,
    input  wire logic                RREADY,
    output logic [31:0]              RDATA,
    output logic [1:0]               RRESP,
    // Processor core
    input  wire logic                INSTR_END,
    input  wire logic                RETURN_FROM_IRQ_INSTR_EXEC,
    input  wire logic                WAIT_EXEC,
    input  wire logic                STOP_EXEC,
    input  wire logic                WDOG_ACTIVE,
    output logic                     ENTRY_PULSE,
    output ixw_pkg::ixw_entry_s      ENTRY,
    output logic                     PC_PUSH,
    output logic                     PC_POP,
    output ixw_pkg::ixw_flagset_e    FLAG_SET,
    output logic                     CORE_HALT,
    output logic                     OSC_RUN,
    // Request pins, idle high; NMI_N and SRC1_N active low, SRC2_PIN edge set by polarity bit
    input  wire logic                NMI_N,
    input  wire logic                SRC1_N,
    input  wire logic                SRC2_PIN,
    // Peripheral events
    input  wire ixw_pkg::ixw_periph_s PERIPH
);
    logic [2:0]              pin_meta_ff;
    logic [2:0]              pin_sync_ff;
    logic [2:0]              pin_prev_ff;
    logic [7:0]              ior_ff;
    logic [7:0]              ena_ff;
    logic                    nmi_lat_ff;
    logic                    src1_lat_ff;
    logic                    src2_lat_ff;
    ixw_pkg::ixw_flagset_e   mode_ff;
    ixw_pkg::ixw_flagset_e   prev_ff;
    ixw_pkg::ixw_pwr_e       pwr_ff;
    logic [15:0]             stab_cnt_ff;
    logic                    aw_hold_ff;
    logic                    w_hold_ff;
    logic [7:0]              aw_addr_ff;
    logic [31:0]             w_data_ff;
    logic [3:0]              w_strb_ff;
    logic                    gen;
    logic                    src1_level_select;
    logic                    src2_edge_polarity;
    logic                    nmi_fall;
    logic                    src1_fall;
    logic                    src2_edge;
    logic [3:0]              raw_req;
    logic [3:0]              mreq;
    logic                    sample;
    logic                    take_nmi;
    logic                    take_m;
    logic [1:0]              pick;
    logic                    pend_en;
    logic                    wake_wait;
    logic                    wake_stop;
    logic                    stab_done;
    logic                    wr_go;

    // Fixed priority, source 1 first
    function automatic logic [1:0] prio(input logic [3:0] r);
        prio = 2'h3;
        if (r[2]) prio = 2'h2;
        if (r[1]) prio = 2'h1;
        if (r[0]) prio = 2'h0;
    endfunction

    function automatic logic [11:0] vec_of(input logic [1:0] idx);
        case (idx)
            2'h0:    vec_of = `IXW_VEC_SRC1;
            2'h1:    vec_of = `IXW_VEC_SRC2;
            2'h2:    vec_of = `IXW_VEC_SRC3;
            default: vec_of = `IXW_VEC_SRC4;
        endcase
    endfunction

    // Pins cross in through two flops; edges compare the second with a third, delayed copy
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pin_meta_ff <= `IXW_PIN_IDLE;
            pin_sync_ff <= `IXW_PIN_IDLE;
            pin_prev_ff <= `IXW_PIN_IDLE;
        end else begin
            pin_meta_ff <= {SRC2_PIN, SRC1_N, NMI_N};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign gen = ior_ff[`IXW_GEN_BIT];
    assign src1_level_select = ior_ff[`IXW_LES_BIT];
    assign src2_edge_polarity = ior_ff[`IXW_ESB_BIT];
    assign nmi_fall  = pin_prev_ff[0] & ~pin_sync_ff[0];
    assign src1_fall = pin_prev_ff[1] & ~pin_sync_ff[1];
    // RULE25 polarity edge select
    // RULE8 source two polarity
    assign src2_edge = src2_edge_polarity ? (~pin_prev_ff[2] & pin_sync_ff[2])
                           : (pin_prev_ff[2] & ~pin_sync_ff[2]);

    // RULE7 level or latched edge
    assign raw_req[0] = (src1_level_select ? ~pin_sync_ff[1] : src1_lat_ff) | PERIPH.spi_done;
    assign raw_req[1] = src2_lat_ff;
    // RULE11 timer events to three
    assign raw_req[2] = (PERIPH.timer1_zero_flag & ena_ff[`IXW_EN_TMR1])
                      | (PERIPH.reload_timer_wrap_flag & ena_ff[`IXW_EN_WRAP])
                      | (PERIPH.reload_timer_match_flag & ena_ff[`IXW_EN_MATCH]);
    // RULE12 converter to four
    // RULE13 serial events to four
    assign raw_req[3] = (PERIPH.converter_eoc & ena_ff[`IXW_EN_CONV])
                      | (PERIPH.serial_byte_received_flag & ena_ff[`IXW_EN_RX])
                      | (PERIPH.serial_byte_sent_flag & ena_ff[`IXW_EN_TX]);
    // RULE9 global enable gate
    assign mreq = gen ? raw_req : 4'h0;

    // RULE24 sample at instruction end
    assign sample = (INSTR_END & (pwr_ff == ixw_pkg::PW_RUN)) | wake_wait | stab_done;
    // RULE22 NMI preempts anything but itself
    assign take_nmi = sample & nmi_lat_ff & (mode_ff != ixw_pkg::FS_NMI);
    // RULE3 maskables only from main routine
    assign take_m = sample & ~take_nmi & (mode_ff == ixw_pkg::FS_NORMAL) & (|mreq);
    assign pick = prio(mreq);
    assign pend_en = (|mreq) | nmi_lat_ff;

    // RULE23 edge latches, set wins over clear
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            nmi_lat_ff  <= 1'b0;
            src1_lat_ff <= 1'b0;
            src2_lat_ff <= 1'b0;
        end else begin
            // RULE4 latch cleared on entry
            if (nmi_fall)
                nmi_lat_ff <= 1'b1;
            else if (take_nmi)
                nmi_lat_ff <= 1'b0;
            if (src1_fall & ~src1_level_select)
                src1_lat_ff <= 1'b1;
            else if ((take_m & (pick == 2'h0)) | src1_level_select)
                src1_lat_ff <= 1'b0;
            if (src2_edge)
                src2_lat_ff <= 1'b1;
            else if (take_m & (pick == 2'h1))
                src2_lat_ff <= 1'b0;
        end
    end

    // RULE1 flag pair follows mode
    // RULE5 return restores previous set
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            mode_ff <= ixw_pkg::FS_NORMAL;
            prev_ff <= ixw_pkg::FS_NORMAL;
        end else if (RETURN_FROM_IRQ_INSTR_EXEC) begin
            mode_ff <= (mode_ff == ixw_pkg::FS_NMI) ? prev_ff : ixw_pkg::FS_NORMAL;
            prev_ff <= ixw_pkg::FS_NORMAL;
        end else if (take_nmi) begin
            mode_ff <= ixw_pkg::FS_NMI;
            prev_ff <= mode_ff;
        end else if (take_m) begin
            mode_ff <= ixw_pkg::FS_IRQ;
        end
    end
    assign FLAG_SET = mode_ff;

    // RULE2 push then vector load
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ENTRY_PULSE <= 1'b0;
            PC_PUSH     <= 1'b0;
            PC_POP      <= 1'b0;
            ENTRY       <= '{vector: `IXW_VEC_NMI, flag_set: ixw_pkg::FS_NORMAL};
        end else begin
            ENTRY_PULSE <= take_nmi | take_m;
            PC_PUSH     <= take_nmi | take_m;
            PC_POP      <= RETURN_FROM_IRQ_INSTR_EXEC;
            if (take_nmi)
                ENTRY <= '{vector: `IXW_VEC_NMI, flag_set: ixw_pkg::FS_NMI};
            else if (take_m)
                ENTRY <= '{vector: vec_of(pick), flag_set: ixw_pkg::FS_IRQ};
        end
    end

    // RULE10 wake needs global enable
    assign wake_wait = (pwr_ff == ixw_pkg::PW_WAIT) & gen & pend_en;
    assign wake_stop = (pwr_ff == ixw_pkg::PW_STOP) & gen
                     & (nmi_lat_ff | src2_lat_ff | raw_req[0]);
    assign stab_done = (pwr_ff == ixw_pkg::PW_STAB)
                     & (stab_cnt_ff == 16'(`IXW_STAB_CYC - 1));

    // Block runs on a free clock; the core clock is what STOP gates.
    // RULE18 reset returns to run
    // RULE21 oscillator selection untouched
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pwr_ff      <= ixw_pkg::PW_RUN;
            stab_cnt_ff <= 16'h0000;
        end else begin
            case (pwr_ff)
                ixw_pkg::PW_RUN: begin
                    // RULE16 STOP only with watchdog off
                    if (STOP_EXEC & ~pend_en)
                        pwr_ff <= WDOG_ACTIVE ? ixw_pkg::PW_WAIT : ixw_pkg::PW_STOP;
                    // RULE14 WAIT freezes the core
                    else if (WAIT_EXEC & ~pend_en)
                        pwr_ff <= ixw_pkg::PW_WAIT;
                end
                ixw_pkg::PW_WAIT: begin
                    // RULE15 no settling after WAIT
                    // RULE19 entry follows wake at once
                    if (wake_wait)
                        pwr_ff <= ixw_pkg::PW_RUN;
                end
                ixw_pkg::PW_STOP: begin
                    if (wake_stop) begin
                        pwr_ff      <= ixw_pkg::PW_STAB;
                        stab_cnt_ff <= 16'h0000;
                    end
                end
                ixw_pkg::PW_STAB: begin
                    // RULE17 settle before first instruction
                    // RULE20 NMI mode blocks any entry
                    if (stab_done)
                        pwr_ff <= ixw_pkg::PW_RUN;
                    else
                        stab_cnt_ff <= stab_cnt_ff + 16'h0001;
                end
                default: pwr_ff <= ixw_pkg::PW_RUN;
            endcase
        end
    end
    assign CORE_HALT = (pwr_ff != ixw_pkg::PW_RUN);
    assign OSC_RUN   = (pwr_ff != ixw_pkg::PW_STOP);

    // Write channels are taken in either order, answered once both held
    assign AWREADY = ~aw_hold_ff & ~BVALID;
    assign WREADY  = ~w_hold_ff & ~BVALID;
    assign wr_go   = aw_hold_ff & w_hold_ff & ~BVALID;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h00000000;
            w_strb_ff  <= 4'h0;
        end else begin
            if (AWVALID & AWREADY) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= AWADDR;
            end else if (wr_go) begin
                aw_hold_ff <= 1'b0;
            end
            if (WVALID & WREADY) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end else if (wr_go) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // RULE6 option register, write only
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ior_ff <= `IXW_IOR_RST;
            ena_ff <= `IXW_ENA_RST;
        end else if (wr_go & w_strb_ff[0]) begin
            if (aw_addr_ff == `IXW_IOR_ADDR)
                ior_ff <= w_data_ff[7:0] & `IXW_IOR_MASK;
            if (aw_addr_ff == `IXW_ENA_ADDR)
                ena_ff <= w_data_ff[7:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            BVALID <= 1'b0;
            BRESP  <= `IXW_RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= ((aw_addr_ff == `IXW_IOR_ADDR) | (aw_addr_ff == `IXW_ENA_ADDR))
                      ? `IXW_RESP_OKAY : `IXW_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Option register reads zero: software must keep its own copy
    assign ARREADY = ~RVALID;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h00000000;
            RRESP  <= `IXW_RESP_OKAY;
        end else if (ARVALID & ARREADY) begin
            RVALID <= 1'b1;
            RRESP  <= `IXW_RESP_OKAY;
            case (ARADDR)
                `IXW_IOR_ADDR:  RDATA <= 32'h00000000;
                `IXW_ENA_ADDR:  RDATA <= {24'h000000, ena_ff};
                `IXW_STAT_ADDR: RDATA <= {23'h000000, nmi_lat_ff, raw_req, pwr_ff, mode_ff};
                default: begin
                    RDATA <= 32'h00000000;
                    RRESP <= `IXW_RESP_SLVERR;
                end
            endcase
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_entry;
        ENTRY_PULSE && PC_PUSH;
    endsequence
    sequence s_irq_set;
        FLAG_SET == ixw_pkg::FS_IRQ;
    endsequence

    chk_flag_swap: assert property (take_m && !RETURN_FROM_IRQ_INSTR_EXEC |=> s_irq_set) // RULE1
        else $error("flag set not switched on entry");
    chk_pc_push: assert property ((take_nmi || take_m) |=> s_entry) // RULE2
        else $error("no push on entry");
    chk_mask_inh: assert property (mode_ff != ixw_pkg::FS_NORMAL |-> !take_m) // RULE3
        else $error("maskable taken in service");
    chk_latch_clr: assert property (take_nmi && !nmi_fall |=> !nmi_lat_ff) // RULE4
        else $error("nmi latch kept after entry");
    chk_return_from_irq_instr_pop: assert property (RETURN_FROM_IRQ_INSTR_EXEC |=> PC_POP ##1 !PC_POP) // RULE5
        else $error("no single pop on return");
    chk_gen_gate: assert property (!gen |-> !take_m) // RULE9
        else $error("maskable taken while disabled");
    chk_nmi_nowake: assert property (pwr_ff inside {ixw_pkg::PW_WAIT, ixw_pkg::PW_STOP} && !gen // RULE10
        |=> CORE_HALT)
        else $error("wake with enable low");
    chk_wait_fast: assert property (wake_wait |=> !CORE_HALT && OSC_RUN) // RULE15
        else $error("wait wake delayed");
    chk_stab_hold: assert property (pwr_ff == ixw_pkg::PW_STAB && !stab_done |=> CORE_HALT) // RULE17
        else $error("stop wake without settling");
    chk_prio_order: assert property (take_m && mreq[0] |=> ENTRY.vector == `IXW_VEC_SRC1) // RULE22
        else $error("priority order broken");
endmodule // ixw_ctrl
